// File: rtl/srx_pkg.sv
// constants, types and register map of the receive lock controller
package srx_pkg;
    // clock period and link framing
    localparam int unsigned CLK_NS = 10;  // pclk period in ns
    localparam logic [2:0] BIT_MID = 3'h4;  // sample phase in 8-cycle bit
    localparam logic [3:0] WORD_LAST = 4'hb;  // 12 bit periods per word
    localparam logic [1:0] BAD_LIMIT = 2'h3;  // fourth bad word drops lock
    localparam logic [1:0] GOOD_TRAIN = 2'h2;  // good words, training
    localparam logic [1:0] GOOD_RANDOM = 2'h3;  // good words, random data
    localparam logic [9:0] TRAINING_PATTERN = 10'h3e0;  // five 1s, five 0s
    localparam logic [5:0] REF_LOSS_CYC = 6'h20;  // no ref edge: absent
    // lock times in ns and in cycles (longest time, rounded down)
    localparam int unsigned T_PD_20_NS = 3500;
    localparam int unsigned T_PD_80_NS = 2500;
    localparam int unsigned T_TR_20_NS = 1500;
    localparam int unsigned T_TR_80_NS = 800;
    localparam logic [11:0] LOCK_PD_20_CYC = 12'(T_PD_20_NS / CLK_NS);
    localparam logic [11:0] LOCK_PD_80_CYC = 12'(T_PD_80_NS / CLK_NS);
    localparam logic [11:0] LOCK_TR_20_CYC = 12'(T_TR_20_NS / CLK_NS);
    localparam logic [11:0] LOCK_TR_80_CYC = 12'(T_TR_80_NS / CLK_NS);
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_INT_STAT = 8'h08;
    localparam logic [7:0] A_INT_MASK = 8'h0c;
    localparam logic [7:0] A_WORD = 8'h10;
    localparam logic [7:0] A_LOSS = 8'h14;
    // field positions and reset values
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_FAST_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    // lock state
    typedef enum logic [1:0] {S_OFF, S_HUNT, S_CHECK, S_LOCK} srx_state_e;
    // pins from outside the clock domain
    typedef struct packed {
        logic ref_clk;
        logic pos;
        logic neg;
        logic pdn_n;
    } srx_pins_s;
    // interrupt events, same layout in status and mask
    typedef struct packed {
        logic timeout;
        logic ref_lost;
        logic lost;
        logic gained;
    } srx_evt_s;
endpackage

// File: rtl/srx_lock_ctrl.sv
// receive lock control: clock-bit checking, lock flag, output enable
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module srx_lock_ctrl
    import srx_pkg::*;
(
    input wire logic pclk,  // 100 MHz clock
    input wire logic presetn,  // async reset, low
    input wire logic [7:0] paddr,  // apb byte address
    input wire logic psel,  // apb select
    input wire logic penable,  // apb access phase
    input wire logic pwrite,  // apb write
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,  // apb read data
    output logic pready,  // apb ready
    output logic pslverr,  // apb error, unmapped
    input wire logic reference_clock_input,  // reference clock pin
    input wire logic serial_input_positive,  // serial line, true
    input wire logic serial_input_negative,  // serial line, inverted
    input wire logic power_down_input_n,  // low: powered down
    output logic [9:0] parallel_receive_outputs,  // recovered word
    output logic parallel_receive_outputs_oe,  // word drive enable
    output logic parallel_receive_strobe,  // new word pulse
    output logic lock_n,  // low while locked
    output logic irq  // level interrupt
);
    // address match, used by read mux and write strobes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a[7:2] == r[7:2]);
    endfunction

    // three-stage pin synchronisers
    srx_pins_s pin_raw;
    logic [3:0] s1_q, s2_q, s3_q;  // stages
    srx_pins_s filt_q;  // value once stages 2 and 3 agree
    assign pin_raw = '{reference_clock_input, serial_input_positive,
                       serial_input_negative, power_down_input_n};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    // glitch filter: only an agreed level passes
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // registers and state
    logic [1:0] ctrl_q;  // enable, fast rate
    srx_evt_s int_stat_q, int_stat_d;  // sticky events
    logic [3:0] int_mask_q;  // interrupt mask
    logic [7:0] loss_q;  // lock losses seen
    srx_state_e st_q, st_d;  // lock state
    logic ref_prev_q;  // last ref level
    logic [5:0] ref_cnt_q;  // cycles since ref edge
    logic din_prev_q;  // last serial level
    logic [2:0] ph_q;  // bit phase
    logic [11:0] sh_q;  // last twelve bits
    logic [3:0] bc_q;  // bit in word
    logic chk_q;  // word ready to judge
    logic [1:0] good_q, bad_q;  // run counters
    logic [11:0] wd_q;  // lock watchdog
    logic wd_sel_q;  // 0: from power-up, 1: relock
    logic [9:0] rout_q;  // output word
    logic oe_q, strb_q, lock_n_q, irq_q;  // output flops
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    // link decode
    logic ref_edge, ref_ok, din, bit_stb, frame_ok, is_train, run;
    logic [1:0] need;
    logic hunting, word_ok, word_bad;
    assign ref_edge = filt_q.ref_clk != ref_prev_q;
    assign ref_ok = ref_cnt_q != REF_LOSS_CYC;
    assign din = filt_q.pos & ~filt_q.neg;
    // phase resets on every transition, sampling mid-bit
    assign bit_stb = ph_q == BIT_MID;
    // start bit high, stop bit low
    assign frame_ok = sh_q[11] & ~sh_q[0];
    assign is_train = sh_q[10:1] == TRAINING_PATTERN;
    assign need = is_train ? GOOD_TRAIN : GOOD_RANDOM;
    assign run = filt_q.pdn_n & ref_ok & ctrl_q[CTRL_EN_BIT];
    assign hunting = (st_q == S_HUNT) || (st_q == S_CHECK);
    assign word_ok = chk_q & frame_ok;
    assign word_bad = chk_q & ~frame_ok;

    // lock state machine
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_OFF: st_d = S_HUNT;  // start hunting once running
            S_HUNT: begin  // random alignment search
                if (word_ok) begin
                    st_d = S_CHECK;
                end
            end
            S_CHECK: begin  // confirm same alignment
                if (word_bad) begin
                    st_d = S_HUNT;
                end else if (word_ok && (good_q + 2'h1 >= need)) begin
                    st_d = S_LOCK;
                end
            end
            S_LOCK: begin
                if (word_bad && bad_q == BAD_LIMIT) begin
                    st_d = S_HUNT;
                end
            end
            default: st_d = S_OFF;  // unused code falls back to off
        endcase
        if (!run) begin
            st_d = S_OFF;
        end
    end
    // watchdog limit: rate and entry path select the lock time
    logic [11:0] wd_lim;
    assign wd_lim = wd_sel_q
        ? (ctrl_q[CTRL_FAST_BIT] ? LOCK_TR_80_CYC : LOCK_TR_20_CYC)
        : (ctrl_q[CTRL_FAST_BIT] ? LOCK_PD_80_CYC : LOCK_PD_20_CYC);

    // events
    srx_evt_s evt;
    assign evt.gained = (st_d == S_LOCK) && (st_q != S_LOCK);
    assign evt.lost = (st_q == S_LOCK) && (st_d != S_LOCK);
    assign evt.ref_lost = ref_cnt_q == REF_LOSS_CYC - 6'h1 && !ref_edge;
    assign evt.timeout = hunting && wd_q == wd_lim - 12'h1;

    // apb decode
    logic setup, wr, mapped;
    logic [31:0] rd_mux;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_q;
    assign mapped = hit(paddr, A_CTRL) | hit(paddr, A_STATUS) |
                    hit(paddr, A_INT_STAT) | hit(paddr, A_INT_MASK) |
                    hit(paddr, A_WORD) | hit(paddr, A_LOSS);
    assign rd_mux =
        hit(paddr, A_CTRL) ? {30'h0, ctrl_q} :
        hit(paddr, A_STATUS) ? {26'h0, st_q, filt_q.pdn_n, is_train,
                                ref_ok, ~lock_n_q} :
        hit(paddr, A_INT_STAT) ? {28'h0, int_stat_q} :
        hit(paddr, A_INT_MASK) ? {28'h0, int_mask_q} :
        hit(paddr, A_WORD) ? {22'h0, rout_q} :
        hit(paddr, A_LOSS) ? {24'h0, loss_q} : 32'h0;
    // event set wins over a write-one clear in the same cycle
    assign int_stat_d = (int_stat_q &
        ~((wr && hit(paddr, A_INT_STAT)) ? pwdata[3:0] : 4'h0)) | evt;
    logic [3:0] int_mask_d;  // mask with this cycle's write, fed to irq
    assign int_mask_d = (wr && hit(paddr, A_INT_MASK)) ? pwdata[3:0] :
                        int_mask_q;

    // apb slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
            ctrl_q <= CTRL_RST;
            int_mask_q <= INT_MASK_RST;
            int_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= setup ? rd_mux : 32'h0;
            if (wr && hit(paddr, A_CTRL)) begin
                ctrl_q <= pwdata[1:0];
            end
            int_mask_q <= int_mask_d;
            int_stat_q <= int_stat_d;
            irq_q <= |(int_stat_d & int_mask_d);
        end
    end

    // link side: reference watch, bit recovery, word framing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_q <= 1'b0;
            ref_cnt_q <= REF_LOSS_CYC;
            din_prev_q <= 1'b0;
            ph_q <= 3'h0;
            sh_q <= 12'h0;
            bc_q <= 4'h0;
            chk_q <= 1'b0;
        end else begin
            ref_prev_q <= filt_q.ref_clk;
            if (ref_edge) begin
                ref_cnt_q <= 6'h0;
            end else if (ref_ok) begin
                ref_cnt_q <= ref_cnt_q + 6'h1;  // saturates when absent
            end
            din_prev_q <= din;
            ph_q <= (din != din_prev_q) ? 3'h0 : ph_q + 3'h1;
            sh_q <= bit_stb ? {sh_q[10:0], din} : sh_q;
            // S_HUNT judges every bit; S_CHECK and S_LOCK judge each twelfth
            chk_q <= bit_stb && run &&
                     (st_q == S_HUNT || bc_q == WORD_LAST);
            if (st_q == S_HUNT) begin
                bc_q <= 4'h0;
            end else if (bit_stb) begin
                bc_q <= (bc_q == WORD_LAST) ? 4'h0 : bc_q + 4'h1;
            end
        end
    end

    // lock bookkeeping and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_OFF;
            good_q <= 2'h0;
            bad_q <= 2'h0;
            wd_q <= 12'h0;
            wd_sel_q <= 1'b0;
            loss_q <= 8'h0;
            rout_q <= 10'h0;
            oe_q <= 1'b0;
            strb_q <= 1'b0;
            lock_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            good_q <= (st_d == S_CHECK && word_ok) ? good_q + 2'h1 :
                      (st_d == S_CHECK) ? good_q : 2'h0;
            // only consecutive bad words count
            bad_q <= (st_q == S_LOCK && word_bad) ? bad_q + 2'h1 :
                     (word_ok ? 2'h0 : bad_q);
            if (st_d == S_OFF) begin
                wd_sel_q <= 1'b0;
                wd_q <= 12'h0;
            end else if (st_d == S_LOCK) begin
                wd_sel_q <= 1'b1;
                wd_q <= 12'h0;
            end else if (hunting) begin
                wd_q <= (wd_q < wd_lim) ? wd_q + 12'h1 : wd_lim;  // clamp
            end
            loss_q <= loss_q + {7'h0, evt.lost};
            // a word leaves only while locked with good clock bits
            strb_q <= word_ok && st_d == S_LOCK;
            if (word_ok && st_d == S_LOCK) begin
                rout_q <= sh_q[10:1];
            end
            oe_q <= st_d == S_LOCK;
            lock_n_q <= st_d != S_LOCK;
        end
    end

    assign parallel_receive_outputs = rout_q;
    assign parallel_receive_outputs_oe = oe_q;
    assign parallel_receive_strobe = strb_q;
    assign lock_n = lock_n_q;
    assign irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_oe_lock;
        oe_q == !lock_n_q;
    endproperty
    a_oe_lock: assert property (p_oe_lock)
        else $error("output enable differs from lock");
    property p_ref_absent;
        !ref_ok |=> lock_n_q && !oe_q;
    endproperty
    a_ref_absent: assert property (p_ref_absent)
        else $error("locked without reference clock");
    property p_pdn;
        !filt_q.pdn_n |=> lock_n_q ##0 !oe_q;
    endproperty
    a_pdn: assert property (p_pdn)
        else $error("locked while powered down");
    property p_fourth_bad;
        st_q == S_LOCK && word_bad && bad_q == BAD_LIMIT |=> lock_n_q;
    endproperty
    a_fourth_bad: assert property (p_fourth_bad)
        else $error("lock kept after four bad words");
    property p_early_bad;
        st_q == S_LOCK && word_bad && bad_q < BAD_LIMIT && run
            |=> !lock_n_q;
    endproperty
    a_early_bad: assert property (p_early_bad)
        else $error("lock dropped before four bad words");
    property p_word_out;
        st_q == S_LOCK && word_ok && run
            |=> strb_q && rout_q == $past(sh_q[10:1]);
    endproperty
    a_word_out: assert property (p_word_out)
        else $error("good word not presented");
    property p_lock_cause;
        $fell(lock_n_q) |-> $past(word_ok) && int_stat_q.gained;
    endproperty
    a_lock_cause: assert property (p_lock_cause)
        else $error("lock without a good word");
    property p_wd_bound;
        wd_q <= wd_lim || $changed(wd_lim);
    endproperty
    a_wd_bound: assert property (p_wd_bound)
        else $error("watchdog beyond lock time");
    property p_irq;
        irq_q == |(int_stat_q & int_mask_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level mismatch");
    c_gain: cover property ($fell(lock_n_q));
    c_loss: cover property (evt.lost);
    c_train: cover property (st_q == S_CHECK && word_ok && is_train);
endmodule // srx_lock_ctrl
`default_nettype wire

// File: tb/srx_ser_model.sv
// serializer partner model: framed serial words and a reference clock
`timescale 1ns/1ps
`default_nettype none
module srx_ser_model
    import srx_pkg::*;
(
    input wire logic tx_en,  // low: line released, bias reads as 1
    input wire logic ref_on,  // reference clock running
    input wire logic req_a,  // training request a
    input wire logic req_b,  // training request b
    input wire logic bad,  // break clock bits of new words
    input wire logic [9:0] data,  // payload when not training
    output logic ref_clk,  // reference clock
    output logic pos,  // serial line, true
    output logic neg,  // serial line, inverted
    output logic [3:0] bad_run  // finished bad words in a row
);
    logic bclk;  // link bit clock, 80 ns
    logic [3:0] idx_q;  // bit index within the word
    logic [11:0] sh_q;  // word being sent
    logic sbad_q;  // current word has broken clock bits
    logic [9:0] w;  // next payload
    logic [11:0] fr;  // next frame, first bit in msb
    logic b;  // bit sent now
    // training pattern while either request is high
    assign w = (req_a | req_b) ? TRAINING_PATTERN : data;
    // start bit 1, ten bits msb first, stop bit 0
    assign fr = bad ? {1'b0, w, 1'b1} : {1'b1, w, 1'b0};
    assign b = (idx_q == 4'h0) ? fr[11] : sh_q[4'hb - idx_q];
    // bit clock, phase unrelated to pclk
    initial begin
        bclk = 1'b0;
        idx_q = 4'h0;
        bad_run = 4'h0;
        sbad_q = 1'b0;
        sh_q = 12'h000;
        pos = 1'b1;
        neg = 1'b0;
        #3;
        forever #40 bclk = ~bclk;
    end
    // reference clock stands still while off
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ref_on ? ~ref_clk : 1'b0;
    end
    // serial sender, one bit per link clock
    always @(posedge bclk) begin
        if (!tx_en) begin
            pos <= 1'b1;
            neg <= 1'b0;
            idx_q <= 4'h0;
        end else begin
            pos <= b;
            neg <= ~b;
            idx_q <= (idx_q == 4'hb) ? 4'h0 : idx_q + 4'h1;
            if (idx_q == 4'h0) begin
                sh_q <= fr;
                sbad_q <= bad;
            end
            // counted as the stop bit goes out
            if (idx_q == 4'hb) begin
                bad_run <= sbad_q ? bad_run + 4'h1 : 4'h0;
            end
        end
    end
endmodule  // srx_ser_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the receive lock controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, err;  // bus side
    logic pdn_n, tx_en, ref_on, fb_en, req_a, req_b, bad;  // link side
    logic [7:0] paddr;  // bus address
    logic [31:0] pwdata, prdata, rd;  // bus data
    logic pready, pslverr, oe, strobe, lock_n, irq;  // outputs
    logic ref_clk, pos, neg;  // link pins
    logic [9:0] pro, data;  // received and sent words
    logic [3:0] bad_run;  // model count of broken words
    int num_errors, n_tests, cyc;  // report counters
    localparam int WORD_CYC = 96;  // twelve bits of eight cycles
    // lock output fed back as training request
    assign req_a = lock_n & fb_en;
    srx_lock_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_input(ref_clk), .serial_input_positive(pos),
        .serial_input_negative(neg), .power_down_input_n(pdn_n),
        .parallel_receive_outputs(pro), .parallel_receive_outputs_oe(oe),
        .parallel_receive_strobe(strobe), .lock_n(lock_n), .irq(irq));
    srx_ser_model ser (.tx_en(tx_en), .ref_on(ref_on), .req_a(req_a),
        .req_b(req_b), .bad(bad), .data(data), .ref_clk(ref_clk),
        .pos(pos), .neg(neg), .bad_run(bad_run));
    // 100 mhz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // one comparison, counted
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    // apb transfer: setup, then access until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, 32'(k < 20));
    endtask
    // read a register and compare the masked value
    task rdchk(input logic [7:0] a, input logic [31:0] m,
               input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd & m);
    endtask
    // bounded wait for a lock output level
    task wait_lock(input logic lvl, input int max);
        int k;
        k = 0;
        while (lock_n !== lvl && k < max) begin
            @(posedge pclk);
            k++;
        end
        chk("lock_n", 32'(lvl), 32'(lock_n));
        @(posedge pclk);
    endtask
    // bounded wait for a given word with its strobe
    task wait_word(input logic [9:0] w);
        int k;
        k = 0;
        while (!(strobe === 1'b1 && pro === w) && k < 400) begin
            @(posedge pclk);
            k++;
        end
        chk("word", 32'(w), 32'(pro));
    endtask
    // the one place the run ends
    task print_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, well above the few thousand cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, presetn, pdn_n, req_b, bad} = 7'h0;
        {tx_en, ref_on, fb_en} = 3'h7;
        paddr = 8'h00;
        pwdata = 32'h0;
        data = 10'h3ff;
        {num_errors, n_tests, cyc} = {32'sd0, 32'sd0, 32'sd0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("lock_n", 32'h1, 32'(lock_n));
        chk("oe", 32'h0, 32'(oe));
        rdchk(A_CTRL, 32'h3, 32'(CTRL_RST), "ctrl");
        rdchk(A_INT_MASK, 32'hf, 32'(INT_MASK_RST), "mask");
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
        apb(1'b1, A_INT_MASK, 32'h3);
        // training runs before power-up, so the longer power-up figure at the slow rate applies
        pdn_n <= 1'b1;
        wait_lock(1'b0, int'(LOCK_PD_20_CYC));
        chk("oe", 32'h1, 32'(oe));
        chk("word", 32'(TRAINING_PATTERN), 32'(pro));
        rdchk(A_INT_STAT, 32'h1, 32'h1, "gained");
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, A_INT_STAT, 32'h1);
        rdchk(A_STATUS, 32'h3, 32'h3, "status");
        chk("irq", 32'h0, 32'(irq));
        data <= 10'h2a5;
        wait_word(10'h2a5);
        rdchk(A_WORD, 32'h3ff, 32'h2a5, "word_reg");
        // loss must wait for the fourth broken word
        bad <= 1'b1;
        wait_lock(1'b1, 800);
        chk("bad_run", 32'h4, 32'(bad_run));
        rdchk(A_INT_STAT, 32'h2, 32'h2, "lost");
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, A_INT_STAT, 32'hf);
        // relock by training; a wrong-phase check may cost a word or two
        bad <= 1'b0;
        wait_lock(1'b0, 5 * WORD_CYC);
        ref_on <= 1'b0;
        wait_lock(1'b1, 200);
        chk("oe", 32'h0, 32'(oe));
        rdchk(A_STATUS, 32'h2, 32'h0, "ref_ok");
        // no training: lock to plain data
        fb_en <= 1'b0;
        data <= 10'h3ff;
        ref_on <= 1'b1;
        wait_lock(1'b0, 3000);
        wait_word(10'h3ff);
        // idle line breaks the clock bits; training from idle relocks
        tx_en <= 1'b0;
        fb_en <= 1'b1;
        wait_lock(1'b1, 5 * WORD_CYC);
        tx_en <= 1'b1;
        wait_lock(1'b0, 5 * WORD_CYC);
        rdchk(A_LOSS, 32'hff, 32'h3, "losses");
        apb(1'b1, A_CTRL, 32'h3);
        rdchk(A_CTRL, 32'h3, 32'h3, "ctrl");
        pdn_n <= 1'b0;
        wait_lock(1'b1, 50);
        chk("oe", 32'h0, 32'(oe));
        print_verdict;
    end
endmodule  // tb
`default_nettype wire
